// ===== hw/ccic_defines.svh
// constants of the clip, compare, copy and instruction-cache clear block
`ifndef CCIC_DEFINES_SVH
`define CCIC_DEFINES_SVH
// operation codes
`define CCIC_OPC_ADD   8'h0c
`define CCIC_OPC_EQL   8'h25
`define CCIC_OPC_CLIP  8'h4a
`define CCIC_OPC_ICLR  8'hb8
// legal issue slots, bit n stands for slot n+1
`define CCIC_SLOTS_ALU  5'h1f
`define CCIC_SLOTS_CLIP 5'h05
`define CCIC_SLOTS_ICLR 5'h0e
// latencies in cycles
`define CCIC_LAT_ALU   1
`define CCIC_LAT_CLIP  2
// instructions i+1, i+2, i+3 after a clear at i are discarded
`define CCIC_DISCARD_SPAN 3
// reset values
`define CCIC_RST_WORD  32'h0000_0000
`define CCIC_RST_DEST  7'h00
// the zero register index
`define CCIC_ZERO_IDX  7'h00
`endif

// ===== hw/ccic_pipe.sv
// one pipeline stage: a valid flag with its data word
`timescale 1ns/100ps
module ccic_pipe #(
    parameter int WIDTH = 32
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RSTN,
    input  wire logic             CE,
    input  wire logic             IN_VALID,
    input  wire logic [WIDTH-1:0] IN_DATA,
    output logic                  OUT_VALID,
    output logic      [WIDTH-1:0] OUT_DATA
);
    if (WIDTH < 1) begin : g_bad_width
        $error("ccic_pipe: WIDTH must be at least 1");
    end
    logic             next_valid; // valid seen next cycle
    logic [WIDTH-1:0] next_data;  // data seen next cycle
    // data is held when invalid, which saves toggling downstream
    always_comb begin
        next_valid = OUT_VALID;
        next_data  = OUT_DATA;
        if (CE) begin
            next_valid = IN_VALID;
            if (IN_VALID) begin
                next_data = IN_DATA;
            end
        end
    end
    // register the stage
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            OUT_VALID <= 1'b0;
            OUT_DATA  <= '0;
        end else begin
            OUT_VALID <= next_valid;
            OUT_DATA  <= next_data;
        end
    end
endmodule : ccic_pipe

// ===== hw/ccic_pkg.sv
// types of the clip, compare, copy and instruction-cache clear block
package ccic_pkg;
    // decoded operation class
    typedef enum logic [2:0] {
        CCIC_OP_NONE = 3'b000,
        CCIC_OP_ADD  = 3'b001,
        CCIC_OP_EQL  = 3'b010,
        CCIC_OP_CLIP = 3'b011,
        CCIC_OP_ICLR = 3'b100
    } ccic_op_t;
    // fetch discard sequence after a clear
    typedef enum logic [1:0] {
        CCIC_DS_IDLE  = 2'b00,
        CCIC_DS_FIRST = 2'b01,
        CCIC_DS_SECND = 2'b10,
        CCIC_DS_THIRD = 2'b11
    } ccic_disc_t;
endpackage : ccic_pkg

// ===== hw/ccic_top.sv
// clip, compare-equal, copy/add and instruction-cache clear execution block
`timescale 1ns/100ps
`include "ccic_defines.svh"
module ccic_top import ccic_pkg::*; #(
    parameter int NBLK = 64, // instruction-cache blocks
    parameter int RIDX = 7   // register index width
) (
    input  wire logic                    SYS_CLK,
    input  wire logic                    RSTN,
    input  wire logic                    CE,
    input  wire logic                    ISSUE_VALID,
    input  wire logic [2:0]              ISSUE_SLOT,
    input  wire logic [7:0]              ISSUE_OPCODE,
    input  wire logic [31:0]             GUARD,
    input  wire logic [RIDX-1:0]         SRC1_IDX,
    input  wire logic [31:0]             FIRST_SOURCE,
    input  wire logic [31:0]             SECOND_SOURCE,
    input  wire logic [RIDX-1:0]         DEST_IDX,
    output logic                         ISSUE_ILLEGAL,
    output logic                         ALU_WB_VALID,
    output logic [RIDX-1:0]              ALU_WB_DEST,
    output logic [31:0]                  ALU_WB_DATA,
    output logic                         DSP_WB_VALID,
    output logic [RIDX-1:0]              DSP_WB_DEST,
    output logic [31:0]                  DSP_WB_DATA,
    input  wire logic                    FILL_EN,
    input  wire logic [$clog2(NBLK)-1:0] FILL_IDX,
    input  wire logic                    FILL_LOCK,
    input  wire logic                    TOUCH_EN,
    input  wire logic [$clog2(NBLK)-1:0] TOUCH_IDX,
    output logic [NBLK-1:0]              BLOCK_VALID,
    output logic [NBLK-1:0]              BLOCK_LOCK,
    output logic [NBLK-1:0]              BLOCK_REPL,
    output logic                         ICACHE_INVALIDATE,
    output logic                         PREFETCH_FLUSH,
    output logic                         FETCH_DISCARD
);
    if (NBLK < 2 || RIDX != 7) begin : g_bad_param
        $error("ccic_top: NBLK must be at least 2 and RIDX must be 7");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    ccic_op_t    op;           // decoded class of the issued operation
    logic [4:0]  slot_bit;     // one-hot slot of the issue
    logic        slot_ok;      // slot legal for the decoded class
    logic        guard_true;   // guard bit zero
    logic        take;         // legal issue with a true guard
    logic        alu_take;     // add or compare-equal taken
    logic        clip_take;    // clip taken
    logic        iclr_take;    // clear taken
    logic [31:0] first_source; // first operand after zero-register forcing

    // slot number 1..5 to a mask bit; slots 0, 6, 7 match nothing
    always_comb begin
        slot_bit = 5'h00;
        if (ISSUE_SLOT >= 3'h1 && ISSUE_SLOT <= 3'h5) begin
            slot_bit = 5'h01 << (ISSUE_SLOT - 3'h1);
        end
    end

    // opcode decode; the copy has no code of its own and lands on add
    always_comb begin
        op      = CCIC_OP_NONE;
        slot_ok = 1'b0;
        if (ISSUE_OPCODE == `CCIC_OPC_ADD) begin
            op      = CCIC_OP_ADD;
            slot_ok = |(slot_bit & `CCIC_SLOTS_ALU);
        end else if (ISSUE_OPCODE == `CCIC_OPC_EQL) begin
            op      = CCIC_OP_EQL;
            slot_ok = |(slot_bit & `CCIC_SLOTS_ALU);
        end else if (ISSUE_OPCODE == `CCIC_OPC_CLIP) begin
            op      = CCIC_OP_CLIP;
            slot_ok = |(slot_bit & `CCIC_SLOTS_CLIP);
        end else if (ISSUE_OPCODE == `CCIC_OPC_ICLR) begin
            op      = CCIC_OP_ICLR;
            slot_ok = |(slot_bit & `CCIC_SLOTS_ICLR);
        end
    end

    // an illegal slot is flagged and the operation has no effect at all
    assign ISSUE_ILLEGAL = ISSUE_VALID && op != CCIC_OP_NONE && !slot_ok;
    assign guard_true    = GUARD[0];
    assign take          = ISSUE_VALID && slot_ok && guard_true;
    assign alu_take      = take && (op == CCIC_OP_ADD || op == CCIC_OP_EQL);
    assign clip_take     = take && op == CCIC_OP_CLIP;
    assign iclr_take     = take && op == CCIC_OP_ICLR;
    // the zero register always reads zero, whatever the port carries
    assign first_source  = (SRC1_IDX == `CCIC_ZERO_IDX) ? 32'h0 : FIRST_SOURCE;

    ////////////////////////////////////////////////////////////////////////////
    // single-cycle arithmetic unit: add, copy, compare-equal
    logic            next_alu_valid; // writeback next cycle
    logic [RIDX-1:0] next_alu_dest;  // destination next cycle
    logic [31:0]     next_alu_data;  // result next cycle
    logic [31:0]     sum;            // wrapping sum

    // the carry out is simply dropped: there is no overflow flag
    assign sum = first_source + SECOND_SOURCE;

    // compute the result; a false guard writes nothing
    always_comb begin
        next_alu_valid = ALU_WB_VALID;
        next_alu_dest  = ALU_WB_DEST;
        next_alu_data  = ALU_WB_DATA;
        if (CE) begin
            next_alu_valid = alu_take;
            if (alu_take) begin
                next_alu_dest = DEST_IDX;
                if (op == CCIC_OP_EQL) begin
                    // equality of signed words is bitwise equality
                    next_alu_data = {31'h0, first_source == SECOND_SOURCE};
                end else begin
                    next_alu_data = sum;
                end
            end
        end
    end

    // register the arithmetic writeback
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ALU_WB_VALID <= 1'b0;
            ALU_WB_DEST  <= `CCIC_RST_DEST;
            ALU_WB_DATA  <= `CCIC_RST_WORD;
        end else begin
            ALU_WB_VALID <= next_alu_valid;
            ALU_WB_DEST  <= next_alu_dest;
            ALU_WB_DATA  <= next_alu_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-stage clip unit
    logic            st1_valid;   // operands latched
    logic [70:0]     st1_data;    // dest, first, second
    logic [31:0]     st1_first;   // latched first operand
    logic [31:0]     st1_second;  // latched bound
    logic [31:0]     clipped;     // clamped value
    logic [38:0]     st2_data;    // dest, result

    // operands are latched first so the compare chain has a full cycle
    ccic_pipe #(.WIDTH(71)) u_clip_opnd (
        .SYS_CLK   (SYS_CLK),
        .RSTN      (RSTN),
        .CE        (CE),
        .IN_VALID  (clip_take),
        .IN_DATA   ({DEST_IDX, first_source, SECOND_SOURCE}),
        .OUT_VALID (st1_valid),
        .OUT_DATA  (st1_data)
    );
    assign st1_first  = st1_data[63:32];
    assign st1_second = st1_data[31:0];

    // clamp; the lower bound -b-1 is ~b, valid only for a nonnegative b
    always_comb begin
        clipped = st1_first;
        if ($signed(st1_first) > $signed(st1_second)) begin
            clipped = st1_second;
        end else if ($signed(st1_first) < $signed(~st1_second)) begin
            clipped = ~st1_second;
        end
    end

    // second stage holds the result for writeback
    ccic_pipe #(.WIDTH(39)) u_clip_res (
        .SYS_CLK   (SYS_CLK),
        .RSTN      (RSTN),
        .CE        (CE),
        .IN_VALID  (st1_valid),
        .IN_DATA   ({st1_data[70:64], clipped}),
        .OUT_VALID (DSP_WB_VALID),
        .OUT_DATA  (st2_data)
    );
    assign DSP_WB_DEST = st2_data[38:32];
    assign DSP_WB_DATA = st2_data[31:0];

    ////////////////////////////////////////////////////////////////////////////
    // instruction-cache block state
    logic [NBLK-1:0] next_valid; // valid bits next cycle
    logic [NBLK-1:0] next_lock;  // lock bits next cycle
    logic [NBLK-1:0] next_repl;  // replacement bits next cycle

    // a fill in the clear cycle is a pending prefetch and is dropped
    always_comb begin
        next_valid = BLOCK_VALID;
        next_lock  = BLOCK_LOCK;
        next_repl  = BLOCK_REPL;
        if (CE) begin
            if (iclr_take) begin
                // locks are ignored here on purpose
                next_valid = '0;
            end else if (FILL_EN) begin
                next_valid[FILL_IDX] = 1'b1;
                next_lock[FILL_IDX]  = FILL_LOCK;
            end
            // replacement state follows use only, never the clear
            if (TOUCH_EN) begin
                next_repl[TOUCH_IDX] = ~BLOCK_REPL[TOUCH_IDX];
            end
        end
    end

    // register the block state
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BLOCK_VALID <= '0;
            BLOCK_LOCK  <= '0;
            BLOCK_REPL  <= '0;
        end else begin
            BLOCK_VALID <= next_valid;
            BLOCK_LOCK  <= next_lock;
            BLOCK_REPL  <= next_repl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear side effects: prefetch flush and fetch discard window
    ccic_disc_t disc;            // discard sequence state
    ccic_disc_t next_disc;       // its next value
    logic       next_inv;        // invalidate pulse next cycle
    logic       next_flush;      // flush pulse next cycle
    logic       next_discard;    // discard level next cycle

    // a false guard never enters the sequence, so it costs no cycle
    always_comb begin
        next_disc    = disc;
        next_inv     = ICACHE_INVALIDATE;
        next_flush   = PREFETCH_FLUSH;
        next_discard = FETCH_DISCARD;
        if (CE) begin
            next_inv   = iclr_take;
            next_flush = iclr_take;
            case (disc)
                CCIC_DS_IDLE:  next_disc = CCIC_DS_IDLE;
                CCIC_DS_FIRST: next_disc = CCIC_DS_SECND;
                CCIC_DS_SECND: next_disc = CCIC_DS_THIRD;
                CCIC_DS_THIRD: next_disc = CCIC_DS_IDLE;
                default:       next_disc = CCIC_DS_IDLE;
            endcase
            // a new clear restarts the window
            if (iclr_take) begin
                next_disc = CCIC_DS_FIRST;
            end
            next_discard = next_disc != CCIC_DS_IDLE;
        end
    end

    // register the side-effect outputs
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            disc              <= CCIC_DS_IDLE;
            ICACHE_INVALIDATE <= 1'b0;
            PREFETCH_FLUSH    <= 1'b0;
            FETCH_DISCARD     <= 1'b0;
        end else begin
            disc              <= next_disc;
            ICACHE_INVALIDATE <= next_inv;
            PREFETCH_FLUSH    <= next_flush;
            FETCH_DISCARD     <= next_discard;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_clip_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (clip_take && CE && !SECOND_SOURCE[31] ##1 CE) |=>
        ($signed(DSP_WB_DATA) <= $signed($past(SECOND_SOURCE, 2)) &&
         $signed(DSP_WB_DATA) >= -$signed($past(SECOND_SOURCE, 2)) - 1)
    ) else $error("clip result outside its range");

    a_clip_latency: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (clip_take && CE ##1 CE) |-> (st1_valid && st1_data[70:64] == $past(DEST_IDX)) ##1
        (DSP_WB_VALID && DSP_WB_DEST == $past(DEST_IDX, 2))
    ) else $error("clip writeback not two cycles after issue");

    a_guard_false: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ISSUE_VALID && !GUARD[0] && CE ##1 CE) |-> !ALU_WB_VALID ##1 !DSP_WB_VALID
    ) else $error("write with a false guard");

    a_clear_all: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (iclr_take && CE) |=> BLOCK_VALID == '0 && ICACHE_INVALIDATE
    ) else $error("valid bits left after clear");

    a_clear_locked: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (iclr_take && CE && |BLOCK_LOCK) |=> (BLOCK_LOCK & BLOCK_VALID) == '0
    ) else $error("locked block kept valid");

    a_repl_kept: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (iclr_take && CE && !TOUCH_EN) |=> $stable(BLOCK_REPL)
    ) else $error("clear changed replacement state");

    a_prefetch_drop: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (iclr_take && CE && FILL_EN) |=> PREFETCH_FLUSH && !BLOCK_VALID[$past(FILL_IDX)]
    ) else $error("prefetch survived a clear");

    a_discard_span: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (iclr_take && CE ##1 (CE && !iclr_take) [*3]) |->
        $past(FETCH_DISCARD, 2) && $past(FETCH_DISCARD) && FETCH_DISCARD ##1 !FETCH_DISCARD
    ) else $error("discard window not three instructions");

    a_clear_slot: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ISSUE_VALID && ISSUE_OPCODE == `CCIC_OPC_ICLR && CE &&
         (ISSUE_SLOT < 3'h2 || ISSUE_SLOT > 3'h4)) |-> ISSUE_ILLEGAL ##1 !PREFETCH_FLUSH
    ) else $error("clear accepted in a bad slot");

    a_clear_guard: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ISSUE_VALID && ISSUE_OPCODE == `CCIC_OPC_ICLR && !GUARD[0] && !FILL_EN &&
         CE && disc == CCIC_DS_IDLE) |=> $stable(BLOCK_VALID) && !FETCH_DISCARD
    ) else $error("false-guarded clear had an effect");

    a_copy_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (alu_take && op == CCIC_OP_ADD && SRC1_IDX == `CCIC_ZERO_IDX && CE) |=>
        ALU_WB_VALID && ALU_WB_DATA == $past(SECOND_SOURCE)
    ) else $error("copy did not pass the source");

    a_eql_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (alu_take && op == CCIC_OP_EQL && CE) |=>
        ALU_WB_DATA == (($past(first_source) == $past(SECOND_SOURCE)) ? 32'h1 : 32'h0)
    ) else $error("compare-equal wrong");

    a_add_wrap: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (alu_take && op == CCIC_OP_ADD && CE) |=>
        ALU_WB_DATA == 32'($past(first_source) + $past(SECOND_SOURCE))
    ) else $error("add not a wrapping sum");
endmodule : ccic_top

// ===== testbench/ccic_top_tb.sv
// self-checking bench of the clip, compare, copy and cache clear block
`timescale 1ns/100ps
`include "ccic_defines.svh"
module ccic_top_tb import ccic_pkg::*; ;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int NBLK = 64;                   // cache blocks
    localparam int NCYC = 1200;                 // driven cycles
    logic              SYS_CLK = 1'b0;          // 50 MHz clock
    logic              RSTN;                    // active low reset
    logic              CE, ISSUE_VALID;         // enable and issue strobe
    logic [2:0]        ISSUE_SLOT;              // slot number
    logic [7:0]        ISSUE_OPCODE;            // operation code
    logic [31:0]       GUARD, FIRST_SOURCE, SECOND_SOURCE;
    logic [6:0]        SRC1_IDX, DEST_IDX;      // register indices
    logic              FILL_EN, FILL_LOCK, TOUCH_EN;
    logic [5:0]        FILL_IDX, TOUCH_IDX;     // block indices
    logic              ISSUE_ILLEGAL, ALU_WB_VALID, DSP_WB_VALID;
    logic [6:0]        ALU_WB_DEST, DSP_WB_DEST;
    logic [31:0]       ALU_WB_DATA, DSP_WB_DATA;
    logic [NBLK-1:0]   BLOCK_VALID, BLOCK_LOCK, BLOCK_REPL;
    logic              ICACHE_INVALIDATE, PREFETCH_FLUSH, FETCH_DISCARD;
    int                errors = 0;              // mismatches
    int                comparisons = 0;         // compares made
    int                seed = 32'hf84229aa;     // fixed seed
    int                i, pick;                 // loop helpers
    logic [31:0]       rb;                      // second source built before driving
    // model state, written only by the model process
    logic              m_alu_v, m_s1_v, m_dsp_v, m_inv;
    logic [6:0]        m_alu_d, m_s1_d, m_dsp_d;
    logic [31:0]       m_alu_x, m_s1_x, m_dsp_x;
    logic [NBLK-1:0]   m_val, m_lock, m_repl;
    int                m_disc;                  // discard cycles left
    // opcodes and directed opening: op, slot, src1 index, a, b
    logic [7:0]  codes [4] = '{`CCIC_OPC_ADD, `CCIC_OPC_EQL, `CCIC_OPC_CLIP, `CCIC_OPC_ICLR};
    logic [7:0]  d_op  [7] = '{8'h0c, 8'h4a, 8'h4a, 8'h25, 8'h0c, 8'hb8, 8'h4a};
    logic [2:0]  d_sl  [7] = '{3'h5, 3'h3, 3'h1, 3'h2, 3'h4, 3'h2, 3'h2};
    logic [6:0]  d_s1  [7] = '{7'h46, 7'h1e, 7'h64, 7'h46, 7'h00, 7'h00, 7'h1e};
    logic [31:0] d_a   [7] = '{32'hffffff00, 32'h80, 32'h80000000, 32'h80000000,
                               32'hdeadbeef, 32'h0, 32'h5};
    logic [31:0] d_b   [7] = '{32'hffffff9c, 32'h7f, 32'h3fffff, 32'h80000000,
                               32'h12345678, 32'h0, 32'h1};

    ccic_top #(.NBLK(NBLK), .RIDX(7)) i_ccic_top (
        .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .ISSUE_VALID(ISSUE_VALID),
        .ISSUE_SLOT(ISSUE_SLOT), .ISSUE_OPCODE(ISSUE_OPCODE), .GUARD(GUARD),
        .SRC1_IDX(SRC1_IDX), .FIRST_SOURCE(FIRST_SOURCE), .SECOND_SOURCE(SECOND_SOURCE),
        .DEST_IDX(DEST_IDX), .ISSUE_ILLEGAL(ISSUE_ILLEGAL), .ALU_WB_VALID(ALU_WB_VALID),
        .ALU_WB_DEST(ALU_WB_DEST), .ALU_WB_DATA(ALU_WB_DATA), .DSP_WB_VALID(DSP_WB_VALID),
        .DSP_WB_DEST(DSP_WB_DEST), .DSP_WB_DATA(DSP_WB_DATA), .FILL_EN(FILL_EN),
        .FILL_IDX(FILL_IDX), .FILL_LOCK(FILL_LOCK), .TOUCH_EN(TOUCH_EN),
        .TOUCH_IDX(TOUCH_IDX), .BLOCK_VALID(BLOCK_VALID), .BLOCK_LOCK(BLOCK_LOCK),
        .BLOCK_REPL(BLOCK_REPL), .ICACHE_INVALIDATE(ICACHE_INVALIDATE),
        .PREFETCH_FLUSH(PREFETCH_FLUSH), .FETCH_DISCARD(FETCH_DISCARD));

    ////////////////////////////////////////////////////////////////////////////////
    // free-running clock
    always #10 SYS_CLK = ~SYS_CLK;

    // known operation codes only; anything else is ignored by the block
    function automatic logic known(input logic [7:0] op);
        return op == codes[0] || op == codes[1] || op == codes[2] || op == codes[3];
    endfunction : known

    // slot legality per unit, slots 0, 6 and 7 match nothing
    function automatic logic slot_ok(input logic [7:0] op, input logic [2:0] sl);
        logic [4:0] mask;
        mask = (op == `CCIC_OPC_CLIP) ? `CCIC_SLOTS_CLIP :
               (op == `CCIC_OPC_ICLR) ? `CCIC_SLOTS_ICLR : `CCIC_SLOTS_ALU;
        return (sl >= 3'h1 && sl <= 3'h5) ? mask[sl - 3'h1] : 1'b0;
    endfunction : slot_ok

    // clamp in 64-bit so minus b minus one never wraps
    function automatic logic [31:0] clip_calc(input logic [31:0] a, input logic [31:0] b);
        longint sa, hi;
        sa = longint'($signed(a));
        hi = longint'(b);
        if (sa < -hi - 1) sa = -hi - 1;
        if (sa > hi) sa = hi;
        return sa[31:0];
    endfunction : clip_calc

    // cycle model, follows the taken edge of every request
    always @(posedge SYS_CLK or negedge RSTN) begin : model
        logic take;
        logic [31:0] opa;
        if (!RSTN) begin
            {m_alu_v, m_s1_v, m_dsp_v, m_inv} = '0;
            {m_alu_d, m_s1_d, m_dsp_d, m_alu_x, m_s1_x, m_dsp_x} = '0;
            {m_val, m_lock, m_repl} = '0;
            m_disc = 0;
        end else if (CE) begin
            // the zero register reads as zero for every operation
            opa = (SRC1_IDX == 7'h00) ? 32'h0 : FIRST_SOURCE;
            take = ISSUE_VALID && known(ISSUE_OPCODE) && slot_ok(ISSUE_OPCODE, ISSUE_SLOT)
                   && GUARD[0];
            m_alu_v = take && (ISSUE_OPCODE == codes[0] || ISSUE_OPCODE == codes[1]);
            if (m_alu_v) begin
                m_alu_d = DEST_IDX;
                // copy is the add with the zero register as first operand
                m_alu_x = (ISSUE_OPCODE == codes[0]) ? (opa + SECOND_SOURCE) :
                          {31'h0, opa == SECOND_SOURCE};
            end
            m_dsp_v = m_s1_v;
            if (m_s1_v) begin
                m_dsp_d = m_s1_d;
                m_dsp_x = m_s1_x;
            end
            m_s1_v = take && ISSUE_OPCODE == codes[2];
            m_s1_d = DEST_IDX;
            m_s1_x = clip_calc(opa, SECOND_SOURCE);
            m_inv = take && ISSUE_OPCODE == codes[3];
            m_disc = m_inv ? 3 : (m_disc > 0 ? m_disc - 1 : 0);
            if (TOUCH_EN) m_repl[TOUCH_IDX] = ~m_repl[TOUCH_IDX];
            // a fill meeting a clear is a pending prefetch and is dropped
            if (m_inv) m_val = '0;
            else if (FILL_EN) begin
                m_val[FILL_IDX] = 1'b1;
                m_lock[FILL_IDX] = FILL_LOCK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one comparison, counted
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // every registered output against the model, at the falling edge
    task automatic check_outputs;
        check(ALU_WB_VALID, m_alu_v);
        check(ALU_WB_DEST, m_alu_d);
        check(ALU_WB_DATA, m_alu_x);
        check(DSP_WB_VALID, m_dsp_v);
        check(DSP_WB_DEST, m_dsp_d);
        check(DSP_WB_DATA, m_dsp_x);
        check(BLOCK_VALID, m_val);
        check(BLOCK_LOCK, m_lock);
        check(BLOCK_REPL, m_repl);
        check(ICACHE_INVALIDATE, m_inv);
        check(PREFETCH_FLUSH, m_inv);
        check(FETCH_DISCARD, m_disc > 0);
    endtask : check_outputs

    // counts, verdict and end of run
    task automatic conclude;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // hang guard, twice the planned run
    initial begin
        #(40 * (NCYC + 20));
        errors++;
        conclude();
    end

    // stimulus: directed opening, then random traffic with one mid-run reset
    initial begin
        {RSTN, CE, ISSUE_VALID, ISSUE_SLOT, ISSUE_OPCODE, GUARD, SRC1_IDX} = '0;
        {FIRST_SOURCE, SECOND_SOURCE, DEST_IDX, FILL_EN, FILL_IDX, FILL_LOCK} = '0;
        {TOUCH_EN, TOUCH_IDX} = '0;
        repeat (3) @(negedge SYS_CLK);
        RSTN = 1'b1;
        for (i = 0; i < NCYC; i++) begin
            @(negedge SYS_CLK);
            check_outputs();
            RSTN = !(i >= 600 && i < 602);
            FILL_EN = 1'($random(seed));
            FILL_IDX = 6'($random(seed));
            FILL_LOCK = 1'($random(seed));
            TOUCH_EN = 1'($random(seed));
            TOUCH_IDX = 6'($random(seed));
            DEST_IDX = 7'($random(seed));
            if (i < 7) begin
                {CE, ISSUE_VALID, GUARD} = {1'b1, 1'b1, 32'h1};
                {ISSUE_OPCODE, ISSUE_SLOT, SRC1_IDX} = {d_op[i], d_sl[i], d_s1[i]};
                {FIRST_SOURCE, SECOND_SOURCE} = {d_a[i], d_b[i]};
            end else begin
                CE = ($random(seed) & 7) != 0;
                ISSUE_VALID = ($random(seed) & 3) != 0;
                pick = $random(seed) & 7;
                ISSUE_OPCODE = pick < 4 ? codes[pick] : 8'($random(seed));
                ISSUE_SLOT = 3'($random(seed));
                GUARD = $random(seed);
                SRC1_IDX = ($random(seed) & 3) == 0 ? 7'h00 : 7'($random(seed));
                FIRST_SOURCE = $random(seed);
                rb = $unsigned($random(seed)) >> ($random(seed) & 31);
                if (($random(seed) & 3) == 0) rb = FIRST_SOURCE;
                // a random code may also land on the clip, so test the code itself
                if (ISSUE_OPCODE == `CCIC_OPC_CLIP) rb[31] = 1'b0;
                SECOND_SOURCE = rb;
            end
            #1;
            if (RSTN && CE && ISSUE_VALID)
                check(ISSUE_ILLEGAL, known(ISSUE_OPCODE) && !slot_ok(ISSUE_OPCODE, ISSUE_SLOT));
        end
        @(negedge SYS_CLK);
        check_outputs();
        conclude();
    end
endmodule : ccic_top_tb
